// ==== design/cmd_interp.sv ====
// Internal command interpreter with APB register access
`timescale 1ns/10ps
module cmd_interp
   import cmd_interp_pkg::*;
#(
   parameter int BASE_CYC = XFER_BASE_CYC,
   parameter int BYTE_CYC = XFER_BYTE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        linkSlave,
   input  wire logic        cpuProtectSw,
   output logic      [31:0] pollResp,
   output logic             busy
);
   state_t        state_q;
   logic [15:0]   cmd_q [6];
   logic [15:0]   diag_q [DIAG_WORDS];
   logic [31:0]   pollResp_q;
   logic [15:0]   protStart_q [MT_COUNT];
   logic [15:0]   protLen_q [MT_COUNT];
   logic [MT_COUNT-1:0] protOn_q;
   logic          slaveS1_q, slaveS2_q, swS1_q, swS2_q;
   logic [31:0]   waitCnt_q;
   logic [10:0]   idx_q;
   logic [10:0]   nBytes_q;
   logic          done_q;
   logic [15:0]   data_q;
   logic [15:0]   dataOut_q;
   logic          dataRdy_q;
   logic [15:0]   dataIn_q;
   logic          dataInV_q;
   logic [3:0]    chkType_q;
   logic [15:0]   chkAddr_q;
   logic          chkProt, wrProt, rdStall;
   logic          wrEn, rdEn, go;
   logic          qbWe;
   logic [QB_AW-1:0] qbAddr;
   logic [7:0]    qbWdata, qbRdata;
   logic          isLoad, isRead;
   logic [15:0]   cmdNum;

   // Type is governed by the CPU switch rather than settings
   function automatic logic switchType(input logic [3:0] t);
      return (t == MT_ABS) || (t >= 4'h4 && t <= 4'h7);
   endfunction

   // Length in bytes from the length word and type of transfer
   function automatic logic [15:0] lenBytes(input logic [15:0] cmd, input logic [15:0] len);
      if (cmd == CMD_LD_REG || cmd == CMD_RD_REG)
         return {len[14:0], 1'b0};
      return {3'h0, len[15:3]};
   endfunction

   // Address is writable under current protection
   function automatic logic writable(input logic [3:0] t, input logic [15:0] a,
                                     input logic sw, input logic on,
                                     input logic [15:0] st, input logic [15:0] ln);
      if (switchType(t))
         return !sw;
      if (!on)
         return 1'b1;
      if (ln == 16'h0000)
         return 1'b0;
      return (a >= st) && ({16'h0, a} < {16'h0, st} + {16'h0, ln});
   endfunction

   assign wrEn   = psel && penable && pwrite && ce;
   assign rdEn   = psel && penable && !pwrite && ce;
   assign pready = 1'b1;
   assign go     = wrEn && paddr == OFS_GO && pwdata[0] && state_q == ST_IDLE;
   assign cmdNum = cmd_q[0];
   assign isLoad = cmdNum >= CMD_LD_REG && cmdNum <= CMD_LD_OUT;
   assign isRead = cmdNum >= CMD_RD_REG && cmdNum <= CMD_RD_OUT;
   assign busy   = state_q != ST_IDLE;
   assign pollResp = pollResp_q;
   assign chkProt = chkType_q < 4'(MT_COUNT) &&
      !writable(chkType_q, chkAddr_q, swS2_q, protOn_q[chkType_q],
                protStart_q[chkType_q], protLen_q[chkType_q]);
   // Protection judged on the type and address being written
   assign wrProt  = pwdata[19:16] < 4'(MT_COUNT) &&
      !writable(pwdata[19:16], pwdata[15:0], swS2_q, protOn_q[pwdata[19:16]],
                protStart_q[pwdata[19:16]], protLen_q[pwdata[19:16]]);
   // Buffer read held while the last word waits to be collected
   assign rdStall = isRead && state_q == ST_XFER && !idx_q[0] && idx_q != 11'h0 && dataRdy_q;

   // Pin synchronisers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         slaveS1_q <= 1'b0;
         slaveS2_q <= 1'b0;
         swS1_q    <= 1'b0;
         swS2_q    <= 1'b0;
      end
      else if (ce)
      begin
         slaveS1_q <= linkSlave;
         slaveS2_q <= slaveS1_q;
         swS1_q    <= cpuProtectSw;
         swS2_q    <= swS1_q;
      end
   end

   // Command block and check registers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < 6; i++)
            cmd_q[i] <= 16'h0000;
         chkType_q <= 4'h0;
         chkAddr_q <= 16'h0000;
      end
      else if (wrEn && state_q == ST_IDLE)
      begin
         if (paddr <= OFS_CMD5 && paddr[1:0] == 2'b00)
            cmd_q[paddr[4:2]] <= pwdata[15:0];
         if (paddr == OFS_PROTCHK)
         begin
            chkType_q <= pwdata[19:16];
            chkAddr_q <= pwdata[15:0];
         end
      end
   end

   // CPU data words pushed in during loads
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         dataIn_q  <= 16'h0000;
         dataInV_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wrEn && paddr == OFS_DATA)
         begin
            dataIn_q  <= pwdata[15:0];
            dataInV_q <= 1'b1;
         end
         else if (state_q == ST_XFER && isLoad && dataInV_q && idx_q[0])
            dataInV_q <= 1'b0;
      end
   end

   // Write protection table, cleared by power-up reset
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         protOn_q <= '0;
         for (int i = 0; i < MT_COUNT; i++)
         begin
            protStart_q[i] <= 16'h0000;
            protLen_q[i]   <= 16'h0000;
         end
      end
      else if (go && cmd_q[0] == CMD_PROTECT && cmd_q[2] < 16'(MT_COUNT)
               && !switchType(cmd_q[2][3:0]))
      begin
         protOn_q[cmd_q[2][3:0]]    <= 1'b1;
         protStart_q[cmd_q[2][3:0]] <= cmd_q[3];
         protLen_q[cmd_q[2][3:0]]   <= cmd_q[4];
      end
   end

   // Poll response payload
   always_ff @(posedge mclk)
   begin
      if (srst)
         pollResp_q <= 32'h0000_0000;
      else if (go && cmd_q[0] == CMD_SET_POLL && slaveS2_q)
         pollResp_q <= {cmd_q[2], cmd_q[1]};
   end

   // Command sequencer
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_q   <= ST_IDLE;
         waitCnt_q <= 32'h0;
         idx_q     <= 11'h0;
         nBytes_q  <= 11'h0;
         done_q    <= 1'b0;
      end
      else if (ce)
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (wrEn && paddr == OFS_STATUS && pwdata[0])
                  done_q <= 1'b0;
               if (go && (isLoad || isRead) && cmd_q[3] < 16'(QB_BYTES) &&
                   {5'h0, lenBytes(cmdNum, cmd_q[4])} + {5'h0, cmd_q[3]} <= 21'(QB_BYTES))
               begin
                  nBytes_q  <= 11'(lenBytes(cmdNum, cmd_q[4]));
                  idx_q     <= 11'h0;
                  waitCnt_q <= 32'(BASE_CYC);
                  state_q   <= ST_XFER;
               end
               else if (go)
                  state_q <= ST_DONE;
            end
            ST_XFER:
            begin
               if (idx_q == nBytes_q && !rdStall)
                  state_q <= ST_WAIT;
               else if (isLoad ? dataInV_q : !rdStall)
               begin
                  idx_q     <= idx_q + 11'h1;
                  waitCnt_q <= waitCnt_q + 32'(BYTE_CYC);
               end
            end
            ST_WAIT:
            begin
               if (waitCnt_q <= 32'h1)
                  state_q <= ST_DONE;
               else
                  waitCnt_q <= waitCnt_q - 32'h1;
            end
            ST_DONE:
            begin
               done_q  <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Buffer port: loads write bytes, reads fetch them
   assign qbAddr  = QB_AW'(cmd_q[3] + {5'h0, idx_q} - {15'h0, rdStall}); // Refetch while held
   assign qbWe    = state_q == ST_XFER && isLoad && dataInV_q && idx_q != nBytes_q;
   assign qbWdata = idx_q[0] ? dataIn_q[15:8] : dataIn_q[7:0];

   qbuf_mem #(.DEPTH(QB_BYTES), .AW(QB_AW)) u_qbuf (
      .mclk  (mclk),
      .ce    (ce),
      .we    (qbWe),
      .addr  (qbAddr),
      .wdata (qbWdata),
      .rdata (qbRdata)
   );

   // Read-out word assembly for buffer reads, one byte behind the address
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         data_q    <= 16'h0000;
         dataOut_q <= 16'h0000;
         dataRdy_q <= 1'b0;
      end
      else if (ce)
      begin
         if (state_q == ST_IDLE && go)
            dataRdy_q <= 1'b0;
         else if (rdEn && paddr == OFS_DATA)
            dataRdy_q <= 1'b0; // Word collected, read may move on
         if (isRead && state_q == ST_XFER && idx_q != 11'h0 && !rdStall)
         begin
            if (idx_q[0])
               data_q[7:0] <= qbRdata;
            else
            begin
               dataOut_q <= {qbRdata, data_q[7:0]};
               dataRdy_q <= 1'b1;
            end
         end
      end
   end

   // Diagnostic words: errors, clearing, software writes
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < DIAG_WORDS; i++)
            diag_q[i] <= 16'h0000;
      end
      else if (ce)
      begin
         if (wrEn && paddr == OFS_DIAGSET && pwdata[20:16] < 5'(DIAG_WORDS))
            diag_q[pwdata[20:16]] <= pwdata[15:0];
         if (go)
         begin
            case (cmdNum)
               CMD_CLR_DIAG:
                  for (int i = 0; i < DIAG_WORDS; i++)
                     if (i + 1 < DIAG_KEEP_LO || i + 1 > DIAG_KEEP_HI)
                        diag_q[i] <= 16'h0000;
               CMD_RD_DIAG:
                  if (cmd_q[3] < 16'h1 || cmd_q[4] == 16'h0 ||
                      {1'b0, cmd_q[3]} + {1'b0, cmd_q[4]} > 17'(DIAG_WORDS + 1))
                     diag_q[DIAG_ERR_WORD-1] <= ERR_DIAG_QB;
               CMD_SET_POLL, CMD_PROTECT:
                  if (cmdNum == CMD_SET_POLL && !slaveS2_q)
                     diag_q[DIAG_ERR_WORD-1] <= ERR_BAD_CMD;
                  else if (cmdNum == CMD_PROTECT && (cmd_q[2] >= 16'(MT_COUNT)
                           || switchType(cmd_q[2][3:0])))
                     diag_q[DIAG_ERR_WORD-1] <= ERR_PROT_TYPE;
               default:
                  if (!isLoad && !isRead)
                     diag_q[DIAG_ERR_WORD-1] <= ERR_BAD_CMD;
                  else if (cmd_q[3] >= 16'(QB_BYTES) ||
                           {5'h0, lenBytes(cmdNum, cmd_q[4])} + {5'h0, cmd_q[3]}
                           > 21'(QB_BYTES))
                     diag_q[DIAG_ERR_WORD-1] <= ERR_DIAG_QB;
            endcase
         end
         else if (wrEn && paddr == OFS_PROTCHK && pwdata[24])
         begin
            if (wrProt)
               diag_q[DIAG_ERR_WORD-1] <= ERR_PROTECTED;
         end
      end
   end

   // APB read mux, diag block read by word index in the window from 0x40
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (psel && !penable && ce)
      begin
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         case (paddr)
            OFS_CMD0, OFS_CMD1, OFS_CMD2, OFS_CMD3, OFS_CMD4, OFS_CMD5:
               prdata <= {16'h0, cmd_q[paddr[4:2]]};
            OFS_STATUS:   prdata <= {29'h0, dataRdy_q, busy, done_q};
            OFS_CFG:      prdata <= {30'h0, swS2_q, slaveS2_q};
            OFS_POLLRESP: prdata <= pollResp_q;
            OFS_DATA:     prdata <= {16'h0, dataOut_q};
            OFS_PROTCHK:  prdata <= {31'h0, chkProt};
            default:
               if (paddr >= 8'h40 && paddr < 8'h40 + 8'(4 * DIAG_WORDS)
                   && paddr[1:0] == 2'b00)
                  prdata <= {16'h0, diag_q[5'((paddr - 8'h40) >> 2)]};
               else if (paddr != OFS_GO && paddr != OFS_DIAGSET)
                  pslverr <= 1'b1;
         endcase
      end
   end
endmodule

// ==== design/cmd_interp_pkg.sv ====
// Constants and types for the internal command interpreter
// What this block does
// - Set-poll-response command 06001 accepted only when configured as link slave.
// - Set-poll-response stores exactly four bytes of the slave poll reply.
// - Word +1 holds bytes 1,2; word +2 bytes 3,4; odd byte low.
// - Command 06002 zeroes status words 1-9 and 13-20, keeps 10-12.
// - Twenty status words; command 06003 only range-checks a consecutive block, CPU reads words from 0x40.
// - Quick buffer holds 1024 bytes, 512 registers, user-structured.
// - Commands 06004-06006 load buffer from registers, inputs, outputs.
// - Commands 06007-06009 copy buffer to registers, inputs, outputs.
// - Each buffer transfer completes within one CPU window, any length.
// - Buffer transfer takes 3.4 ms overhead plus 18 us per byte.
// - Word +3 holds buffer byte address 0 to 1023, zero is first.
// - Register bits 1-8 to lower byte, bits 9-16 to next byte.
// - Command 06010 blocks serial writes to a type except one open block.
// - Zero length protects whole type; each type set independently.
// - Memory type codes 0 to 9 decode as listed.
// - Types 0,4,5,6,7 follow the CPU memory protect switch.
// - Power cycle clears all protection to unprotected.
// - Write to protected memory rejected with error code 04 in word 13.
// - Bad address or length on status words or buffer gives error 03.
package cmd_interp_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFS_CMD0      = 8'h00;
   localparam logic [7:0] OFS_CMD1      = 8'h04;
   localparam logic [7:0] OFS_CMD2      = 8'h08;
   localparam logic [7:0] OFS_CMD3      = 8'h0c;
   localparam logic [7:0] OFS_CMD4      = 8'h10;
   localparam logic [7:0] OFS_CMD5      = 8'h14;
   localparam logic [7:0] OFS_GO        = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h1c;
   localparam logic [7:0] OFS_CFG       = 8'h20;
   localparam logic [7:0] OFS_POLLRESP  = 8'h24;
   localparam logic [7:0] OFS_DATA      = 8'h28;
   localparam logic [7:0] OFS_DIAGSET   = 8'h2c;
   localparam logic [7:0] OFS_PROTCHK   = 8'h30;
   // Command numbers
   localparam logic [15:0] CMD_SET_POLL   = 16'h1771;
   localparam logic [15:0] CMD_CLR_DIAG   = 16'h1772;
   localparam logic [15:0] CMD_RD_DIAG    = 16'h1773;
   localparam logic [15:0] CMD_LD_REG     = 16'h1774;
   localparam logic [15:0] CMD_LD_OUT     = 16'h1776;
   localparam logic [15:0] CMD_RD_REG     = 16'h1777;
   localparam logic [15:0] CMD_RD_OUT     = 16'h1779;
   localparam logic [15:0] CMD_PROTECT    = 16'h177a;
   // Error codes in diagnostic word 13
   localparam logic [15:0] ERR_BAD_CMD    = 16'h0001;
   localparam logic [15:0] ERR_DIAG_QB    = 16'h0003;
   localparam logic [15:0] ERR_PROTECTED  = 16'h0004;
   localparam logic [15:0] ERR_PROT_TYPE  = 16'h000a;
   // Diagnostic words
   localparam int          DIAG_WORDS     = 20;
   localparam int          DIAG_ERR_WORD  = 13;
   localparam int          DIAG_KEEP_LO   = 10;
   localparam int          DIAG_KEEP_HI   = 12;
   // Quick buffer
   localparam int          QB_BYTES       = 1024;
   localparam int          QB_AW          = 10;
   // Memory types
   localparam logic [3:0]  MT_ABS = 4'h0;
   localparam logic [3:0]  MT_REG = 4'h1;
   localparam logic [3:0]  MT_IN  = 4'h2;
   localparam logic [3:0]  MT_OUT = 4'h3;
   localparam logic [3:0]  MT_QB  = 4'h8;
   localparam logic [3:0]  MT_DIAG = 4'h9;
   localparam int          MT_COUNT = 10;
   // Transfer timing
   localparam real         CLK_MHZ        = 125.0;
   localparam real         XFER_BASE_US   = 3400.0;
   localparam real         XFER_BYTE_US   = 18.0;
   localparam int          XFER_BASE_CYC  = int'(XFER_BASE_US * CLK_MHZ);
   localparam int          XFER_BYTE_CYC  = int'(XFER_BYTE_US * CLK_MHZ);
   typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_WAIT, ST_DONE} state_t;
endpackage

// ==== design/qbuf_mem.sv ====
// Quick buffer byte memory with registered read data
`timescale 1ns/10ps
module qbuf_mem #(
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   input  wire logic          mclk,
   input  wire logic          ce,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [DEPTH];

   // Write then registered read
   always_ff @(posedge mclk)
   begin
      if (ce)
      begin
         if (we)
            mem[addr] <= wdata;
         rdata <= mem[addr];
      end
   end
endmodule

// ==== sim/cmd_interp_asserts.sv ====
// Port checks for the command interpreter
`timescale 1ns/10ps
module cmd_interp_asserts
   import cmd_interp_pkg::*;
#(
   parameter int BASE_CYC = 20,
   parameter int BYTE_CYC = 2
) (
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        linkSlave,
   input wire logic        cpuProtectSw,
   input wire logic [31:0] pollResp,
   input wire logic        busy
);
   // Mapped read window and access phase
   wire logic mapped = ((paddr <= OFS_PROTCHK) || (paddr >= 8'h40 && paddr <= 8'h8c))
                       && paddr[1:0] == 2'b00;
   wire logic acc    = psel && penable;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Bus answer and error flag
   property p_readyHigh; pready; endproperty
   a_readyHigh: assert property (p_readyHigh) else $error("pready low");
   property p_slvRd; acc && !pwrite |-> pslverr == !mapped; endproperty
   a_slvRd: assert property (p_slvRd) else $error("pslverr wrong on read");
   property p_slvWr; acc && pwrite |-> !pslverr; endproperty
   a_slvWr: assert property (p_slvWr) else $error("pslverr on write");
   // Status busy bit follows busy of the setup cycle
   property p_stBusy; acc && !pwrite && paddr == OFS_STATUS && $past(ce) |-> prdata[1] == $past(busy); endproperty
   a_stBusy: assert property (p_stBusy) else $error("status busy bit wrong");
   // Reset leaves reply empty and idle
   property p_rstClr; $past(srst) && $past(ce) |-> pollResp == 32'h0 && !busy && !pslverr; endproperty
   a_rstClr: assert property (p_rstClr) else $error("state not cleared by reset");
   // Clock enable freezes state
   property p_ceFrz; !ce |=> $stable(pollResp) && $stable(busy); endproperty
   a_ceFrz: assert property (p_ceFrz) else $error("state moved with ce low");
   // Reply untouched while not a link slave
   sequence s_noSlave; !linkSlave ##1 !linkSlave ##1 !linkSlave ##1 !linkSlave; endsequence
   property p_pollSlv; s_noSlave |-> $stable(pollResp); endproperty
   a_pollSlv: assert property (p_pollSlv) else $error("reply changed on master");
   // Read data stands between transfers
   property p_rdHold; !psel |=> $stable(prdata); endproperty
   a_rdHold: assert property (p_rdHold) else $error("prdata moved while idle");
   c_busy: cover property ($rose(busy));
   c_err: cover property (acc && pslverr);
   c_poll: cover property ($changed(pollResp));
endmodule

bind cmd_interp cmd_interp_asserts #(.BASE_CYC(BASE_CYC), .BYTE_CYC(BYTE_CYC)) cmd_interp_asserts_inst (
   .mclk(mclk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .linkSlave(linkSlave), .cpuProtectSw(cpuProtectSw), .pollResp(pollResp), .busy(busy));

// ==== sim/cpu_model.sv ====
// Bus master model of the controller CPU issuing command blocks
`timescale 1ns/10ps
module cpu_model (
   input  wire logic        mclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata
);
   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer: setup, access until ready, then release
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a; // Released lines do not keep old value
      pwdata <= ~d;
   endtask
endmodule

// ==== sim/test_cmd_interp.sv ====
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
module test_cmd_interp
   import cmd_interp_pkg::*;
;
   localparam int BASE = 20;
   localparam int BYTE = 2;
   localparam logic [15:0] zw = 16'h0;
   typedef struct packed {
      logic [15:0] c, w1, w2, w3, w4;
      logic        slv;
      logic [15:0] err;
   } row_t;
   // Command, words +1 to +4, slave pin, expected error word
   row_t rows [10] = '{
      '{CMD_SET_POLL, 16'h0201, 16'h0403, zw, zw, 1'b1, zw},
      '{CMD_SET_POLL, 16'h1111, 16'h2222, zw, zw, 1'b0, ERR_BAD_CMD},
      '{CMD_SET_POLL, 16'ha5b6, 16'hc7d8, 16'h0009, 16'h0009, 1'b1, zw},
      '{CMD_RD_DIAG, zw, zw, 16'h1, 16'h14, 1'b1, zw},
      '{CMD_RD_DIAG, zw, zw, 16'h1, 16'h15, 1'b1, ERR_DIAG_QB},
      '{CMD_LD_REG, zw, zw, 16'h3ff, 16'h1, 1'b1, ERR_DIAG_QB},
      '{CMD_RD_REG, zw, zw, 16'h400, 16'h1, 1'b1, ERR_DIAG_QB},
      '{CMD_PROTECT, zw, 16'h4, zw, zw, 1'b1, ERR_PROT_TYPE},
      '{CMD_PROTECT, zw, 16'ha, zw, zw, 1'b1, ERR_PROT_TYPE},
      '{16'h1234, zw, zw, zw, zw, 1'b1, ERR_BAD_CMD}};
   logic        mclk, srst, ce, psel, penable, pwrite, pready, pslverr, busy, err;
   logic        linkSlave, cpuProtectSw;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, pollResp, v, expPoll;
   int          numErrors, totalChecks, b0, i;
   int          busyCnt = 0;
   cmd_interp #(.BASE_CYC(BASE), .BYTE_CYC(BYTE)) cmd_interp_inst (
      .mclk(mclk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .linkSlave(linkSlave), .cpuProtectSw(cpuProtectSw), .pollResp(pollResp), .busy(busy));
   cpu_model cpu_model_inst (
      .mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // Clock and busy cycle count
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;
   always @(posedge mclk) busyCnt <= busyCnt + ((busy === 1'b1) ? 1 : 0);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         numErrors++;
         $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      cpu_model_inst.xfer(1'b1, a, d, x, err);
   endtask
   task automatic rdv(input logic [7:0] a);
      cpu_model_inst.xfer(1'b0, a, 32'h0, v, err);
   endtask
   // Command block then start
   task automatic issue(input logic [5:0][15:0] w);
      for (int k = 0; k < 6; k++)
         wr(OFS_CMD0 + 8'(4 * k), {16'h0, w[k]});
      wr(OFS_GO, 32'h1);
   endtask
   task automatic waitDone();
      v = 32'h0;
      for (int k = 0; k < 3000 && v[0] !== 1'b1; k++)
         rdv(OFS_STATUS);
      chk({31'h0, v[0]}, 32'h1);
      wr(OFS_STATUS, 32'h1);
   endtask
   // Buffer transfer with data words moved through DATA
   task automatic qb(input logic [15:0] c, a, n, input logic ld, input logic [15:0] d0, d1,
                     input int cnt);
      logic [15:0] d;
      issue({16'h0032, n, a, 32'h0, c});
      for (int k = 0; k < cnt; k++)
      begin
         d = (k == 0) ? d0 : d1;
         v = 32'h0;
         if (ld)
            wr(OFS_DATA, {16'h0, d});
         else
         begin
            for (int j = 0; j < 200 && v[2] !== 1'b1; j++)
               rdv(OFS_STATUS);
            rdv(OFS_DATA);
            chk({16'h0, v[15:0]}, {16'h0, d});
         end
      end
      waitDone();
   endtask
   task automatic pc(input logic [3:0] t, input logic [15:0] a, input logic e);
      wr(OFS_PROTCHK, {12'h0, t, a});
      rdv(OFS_PROTCHK);
      chk({31'h0, v[0]}, {31'h0, e});
   endtask
   task automatic completeRun();
      $display("Checks %0d, errors %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #400000;
      numErrors++;
      completeRun();
   end
   initial
   begin
      srst = 1'b1;
      ce = 1'b1;
      linkSlave = 1'b0;
      cpuProtectSw = 1'b0;
      expPoll = 32'h0;
      numErrors = 0;
      totalChecks = 0;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      for (i = 0; i < 10; i++)
      begin
         linkSlave <= rows[i].slv;
         repeat (4) @(posedge mclk);
         wr(OFS_DIAGSET, {11'h0, 5'hc, 16'h0});
         issue({16'h0032, rows[i].w4, rows[i].w3, rows[i].w2, rows[i].w1, rows[i].c});
         waitDone();
         if (rows[i].c == CMD_SET_POLL && rows[i].slv)
            expPoll = {rows[i].w2, rows[i].w1};
         rdv(8'h70);
         chk({16'h0, v[15:0]}, {16'h0, rows[i].err});
         chk(pollResp, expPoll);
      end
      // Clear keeps words 10 to 12
      for (i = 0; i < 20; i++)
         wr(OFS_DIAGSET, {11'h0, 5'(i), 16'h0100 + 16'(i)});
      issue({80'h0, CMD_CLR_DIAG});
      waitDone();
      for (i = 0; i < 20; i++)
      begin
         rdv(8'h40 + 8'(4 * i));
         chk({16'h0, v[15:0]}, (i >= 9 && i <= 11) ? 32'h100 + 32'(i) : 32'h0);
      end
      // Buffer timing, byte order and boundaries
      b0 = busyCnt;
      qb(CMD_LD_REG, 16'h2, 16'h2, 1'b1, 16'h0201, 16'h0403, 2);
      b0 = busyCnt - b0;
      chk({31'h0, b0 >= BASE + 4 * BYTE && b0 <= BASE + 4 * BYTE + 40}, 32'h1);
      qb(CMD_RD_REG, 16'h3, 16'h1, 1'b0, 16'h0302, zw, 1);
      qb(CMD_LD_REG + 16'h1, 16'h3fe, 16'h10, 1'b1, 16'hbeef, zw, 1);
      qb(CMD_RD_REG, 16'h3fe, 16'h1, 1'b0, 16'hbeef, zw, 1);
      qb(CMD_RD_OUT, 16'h2, 16'h20, 1'b0, 16'h0201, 16'h0403, 2);
      // Clock enable low holds a running load
      issue({16'h0032, 16'h10, 16'h0, 32'h0, CMD_LD_OUT});
      ce <= 1'b0;
      repeat (6) @(posedge mclk);
      chk({31'h0, busy}, 32'h1);
      ce <= 1'b1;
      wr(OFS_DATA, 32'h1357);
      waitDone();
      qb(CMD_RD_REG + 16'h1, 16'h0, 16'h10, 1'b0, 16'h1357, zw, 1);
      // Open block on registers, whole lock on inputs
      issue({16'h0, 16'h32, 16'h1, 16'h1, 16'h0, CMD_PROTECT});
      waitDone();
      issue({16'h0, 16'h0, 16'h0, 16'h2, 16'h0, CMD_PROTECT});
      waitDone();
      pc(4'h1, 16'h1, 1'b0);
      pc(4'h1, 16'h32, 1'b0);
      pc(4'h1, 16'h0, 1'b1);
      pc(4'h1, 16'h33, 1'b1);
      pc(4'h2, 16'h40, 1'b1);
      pc(4'h3, 16'h40, 1'b0);
      pc(4'h8, 16'h40, 1'b0);
      cpuProtectSw <= 1'b1;
      repeat (4) @(posedge mclk);
      pc(4'h0, 16'h5, 1'b1);
      pc(4'h6, 16'h5, 1'b1);
      rdv(OFS_CFG);
      chk({30'h0, v[1:0]}, 32'h3);
      cpuProtectSw <= 1'b0;
      repeat (4) @(posedge mclk);
      pc(4'h7, 16'h5, 1'b0);
      wr(OFS_DIAGSET, {11'h0, 5'hc, 16'h0});
      wr(OFS_PROTCHK, {7'h0, 1'b1, 4'h0, 4'h1, 16'h0});
      rdv(8'h70);
      chk({16'h0, v[15:0]}, {16'h0, ERR_PROTECTED});
      // Second reset clears protection and reply
      srst <= 1'b1;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk(pollResp, 32'h0);
      pc(4'h1, 16'h0, 1'b0);
      pc(4'h2, 16'h40, 1'b0);
      rdv(OFS_STATUS);
      chk(v, 32'h0);
      rdv(8'h34);
      chk({31'h0, err}, 32'h1);
      completeRun();
   end
endmodule
